// file: core/ccrh_mailbox.sv
`timescale 1ns/1ps
module ccrh_mailbox
    import ccrh_pkg::*;
#(
    parameter int N_TRIB = 4,
    parameter int CNT_W  = 8
) (
    // clock and reset
    input  wire logic       i_clock,
    input  wire logic       i_rst,
    // host byte registers
    input  wire logic [2:0] i_csr_addr,
    input  wire logic       i_csr_wr,
    input  wire logic       i_csr_rd,
    input  wire logic [7:0] i_csr_wdata,
    output logic      [7:0] o_csr_rdata,
    // host interrupts
    output logic            o_irq_in,
    output logic            o_irq_out,
    output logic      [2:0] o_irq_vector,
    // controller side
    input  wire logic [15:0] i_modem_status,
    input  wire logic        i_evt_valid,
    input  wire logic [7:0]  i_evt_trib,
    input  wire logic        i_buf_assign,
    input  wire logic        i_buf_common,
    input  wire logic [7:0]  i_buf_trib,
    output logic             o_cmd_valid,
    output ccrh_msg_t        o_cmd,
    output logic             o_running
);

    localparam int TW    = (N_TRIB > 1) ? $clog2(N_TRIB) : 1;
    localparam int AW    = TW + SLOT_ADDR_W;
    localparam int DEPTH = 2**AW;

    // ==========================================================
    // state
    typedef struct packed {
        ccrh_state_t           st;
        logic                  input_irq_enable;
        logic                  output_irq_enable;
        logic                  port_request_flag;
        logic                  run;
        logic                  mclr;
        logic [2:0]            hsk_code;
        logic                  port_granted_flag;
        logic                  response_pending_flag;
        logic [7:0]            trib;
        logic [15:0]           data;
        logic [7:0]            sel;
        logic [7:0]            rdata;
        logic                  irq_in;
        logic                  irq_out;
        logic [2:0]            vec;
        logic [INIT_CNT_W-1:0] init_cnt;
        logic                  rsp_pend;
        ccrh_msg_t             rsp;
        logic                  cmd_valid;
        ccrh_msg_t             cmd;
        logic                  slot_wait;
    } ccrh_main_state_t;

    ccrh_main_state_t s_r;
    ccrh_main_state_t s_nxt;

    logic            slot_rd;
    logic            slot_clr;
    logic            slot_wr;
    logic [AW-1:0]   slot_addr;
    logic [15:0]     slot_wdata;
    logic [15:0]     slot_rdata;
    logic            br_clear;
    logic            br_start;
    logic [7:0]      br_start_trib;
    logic            br_ret_valid;
    logic [7:0]      br_ret_trib;
    logic            br_ret_taken;
    logic            br_done_valid;
    logic [7:0]      br_done_trib;
    logic            br_done_taken;

    function automatic logic [AW-1:0] slot_index(input logic [7:0] trib, input logic [7:0] sel);
        slot_index = {trib[TW-1:0], sel[SLOT_ADDR_W-1:0]};
    endfunction

    // ==========================================================
    // helpers
    ccrh_slot_mem #(
        .AW (AW)
    ) u_slots (
        .i_clock  (i_clock),
        .i_rst    (i_rst),
        .i_rd     (slot_rd),
        .i_rd_clr (slot_clr),
        .i_wr     (slot_wr),
        .i_addr   (slot_addr),
        .i_wdata  (slot_wdata),
        .o_rdata  (slot_rdata)
    );

    ccrh_buf_return #(
        .N_TRIB (N_TRIB),
        .CNT_W  (CNT_W)
    ) u_bufret (
        .i_clock         (i_clock),
        .i_rst           (i_rst),
        .i_clear         (br_clear),
        .i_assign        (i_buf_assign),
        .i_assign_common (i_buf_common),
        .i_assign_trib   (i_buf_trib),
        .i_start         (br_start),
        .i_start_trib    (br_start_trib),
        .o_ret_valid     (br_ret_valid),
        .o_ret_trib      (br_ret_trib),
        .i_ret_taken     (br_ret_taken),
        .o_done_valid    (br_done_valid),
        .o_done_trib     (br_done_trib),
        .i_done_taken    (br_done_taken)
    );

    // ==========================================================
    // next state
    always_comb begin
        logic [2:0] key;
        logic [7:0] sel_v;
        key           = s_r.cmd.sel[7:5];
        sel_v         = {3'b000, s_r.cmd.sel[SLOT_ADDR_W-1:0]};
        s_nxt         = s_r;
        s_nxt.irq_in  = 1'b0;
        s_nxt.irq_out = 1'b0;
        s_nxt.cmd_valid = 1'b0;
        slot_rd       = 1'b0;
        slot_clr      = 1'b0;
        slot_wr       = 1'b0;
        slot_addr     = slot_index(s_r.cmd.trib, s_r.cmd.sel);
        slot_wdata    = 16'h0000;
        br_clear      = 1'b0;
        br_start      = 1'b0;
        br_start_trib = 8'h00;
        br_ret_taken  = 1'b0;
        br_done_taken = 1'b0;

        if (i_csr_rd) begin
            case (i_csr_addr)
                OFF_CTRL_LOW:  s_nxt.rdata = {s_r.port_request_flag, 2'b00, s_r.output_irq_enable, 3'b000, s_r.input_irq_enable};
                OFF_CTRL_HIGH: s_nxt.rdata = {s_r.run, s_r.mclr, 6'h00};
                OFF_HSK:       s_nxt.rdata = {s_r.response_pending_flag, 2'b00, s_r.port_granted_flag, 1'b0, s_r.hsk_code};
                OFF_TRIB:      s_nxt.rdata = s_r.trib;
                OFF_DLO:       s_nxt.rdata = s_r.data[7:0];
                OFF_DHI:       s_nxt.rdata = s_r.data[15:8];
                OFF_SEL:       s_nxt.rdata = s_r.sel;
                default:       s_nxt.rdata = 8'h00;
            endcase
        end

        if (i_csr_wr) begin
            case (i_csr_addr)
                OFF_CTRL_LOW: begin
                    // all three bits land on the same edge
                    s_nxt.input_irq_enable = i_csr_wdata[BIT_IEI];
                    s_nxt.output_irq_enable = i_csr_wdata[BIT_IEO];
                    s_nxt.port_request_flag = i_csr_wdata[BIT_RQI];
                end
                OFF_CTRL_HIGH: begin
                    if (i_csr_wdata[BIT_MCLR]) begin
                        s_nxt.mclr = 1'b1;
                    end
                end
                OFF_HSK: begin
                    s_nxt.hsk_code = i_csr_wdata[2:0];
                    if (!i_csr_wdata[BIT_RDO]) begin
                        s_nxt.response_pending_flag = 1'b0;
                    end
                end
                OFF_TRIB: s_nxt.trib = i_csr_wdata;
                OFF_DLO:  s_nxt.data[7:0] = i_csr_wdata;
                OFF_DHI:  s_nxt.data[15:8] = i_csr_wdata;
                OFF_SEL:  s_nxt.sel = i_csr_wdata;
                default:  s_nxt.sel = s_r.sel;
            endcase
        end

        case (s_r.st)
            ST_INIT: begin
                if (s_r.mclr) begin
                    // clearing the slots rides on the init delay
                    slot_wr   = (32'(s_r.init_cnt) < DEPTH);
                    slot_addr = AW'(s_r.init_cnt);
                    if (32'(s_r.init_cnt) == INIT_CYCLES - 1) begin
                        s_nxt.run  = 1'b1;
                        s_nxt.mclr = 1'b0;
                        s_nxt.st   = ST_IDLE;
                    end else begin
                        s_nxt.init_cnt = s_r.init_cnt + 1'b1;
                    end
                end
            end
            ST_IDLE: begin
                if (!s_r.rsp_pend) begin
                    if (br_ret_valid) begin
                        s_nxt.rsp_pend = 1'b1;
                        s_nxt.rsp      = '{trib: br_ret_trib, data: 16'h0000, sel: 8'h00, code: RSP_BUF_DISP};
                        br_ret_taken   = 1'b1;
                    end else if (br_done_valid) begin
                        s_nxt.rsp_pend = 1'b1;
                        s_nxt.rsp      = '{trib: br_done_trib, data: 16'h0000,
                                           sel: {3'b000, RKEY_BUFDONE}, code: RSP_INFO};
                        br_done_taken  = 1'b1;
                    end
                end
                // own responses go first; a waiting host gets the port afterwards
                if (s_r.rsp_pend) begin
                    s_nxt.st = ST_LOAD;
                end else if (s_r.port_request_flag && !br_ret_valid && !br_done_valid) begin
                    s_nxt.st     = ST_GRANT;
                    s_nxt.port_granted_flag    = 1'b1;
                    s_nxt.irq_in = s_r.input_irq_enable;
                    s_nxt.vec    = VEC_IN;
                end
            end
            ST_GRANT: begin
                // writing the type byte hands the command over
                if (i_csr_wr && i_csr_addr == OFF_HSK) begin
                    s_nxt.port_granted_flag = 1'b0;
                    s_nxt.st  = ST_EXEC;
                    s_nxt.cmd = '{trib: s_r.trib, data: s_r.data, sel: s_r.sel, code: i_csr_wdata[2:0]};
                end
            end
            ST_EXEC: begin
                s_nxt.st = ST_IDLE;
                if (s_r.slot_wait) begin
                    sel_v[BIT_SEL_RDCLR] = (key == KEY_RDCLR);
                    sel_v[BIT_SEL_READ]  = (key == KEY_READ);
                    s_nxt.slot_wait = 1'b0;
                    s_nxt.rsp_pend  = 1'b1;
                    s_nxt.rsp       = '{trib: s_r.cmd.trib, data: slot_rdata, sel: sel_v, code: RSP_INFO};
                end else if (s_r.cmd.code != CMD_CONTROL) begin
                    s_nxt.cmd_valid = 1'b1;
                end else begin
                    case (key)
                        KEY_MODEM: begin
                            s_nxt.rsp_pend = 1'b1;
                            s_nxt.rsp = '{trib: s_r.cmd.trib, data: i_modem_status,
                                          sel: {3'b000, RKEY_MODEM}, code: RSP_INFO};
                        end
                        KEY_READ, KEY_RDCLR: begin
                            slot_rd         = 1'b1;
                            slot_clr        = (key == KEY_RDCLR);
                            s_nxt.slot_wait = 1'b1;
                            s_nxt.st        = ST_EXEC;
                        end
                        KEY_WRITE: begin
                            slot_wr    = 1'b1;
                            slot_wdata = s_r.cmd.data;
                        end
                        KEY_HALT: begin
                            br_start      = 1'b1;
                            br_start_trib = s_r.cmd.trib;
                        end
                        default: begin
                            s_nxt.st = ST_IDLE;
                        end
                    endcase
                end
            end
            ST_LOAD: begin
                s_nxt.trib = s_r.rsp.trib;
                s_nxt.data = s_r.rsp.data;
                s_nxt.sel  = s_r.rsp.sel;
                s_nxt.st   = ST_POST;
            end
            ST_POST: begin
                if (s_r.rsp_pend) begin
                    s_nxt.response_pending_flag      = 1'b1;
                    s_nxt.hsk_code = s_r.rsp.code;
                    s_nxt.rsp_pend = 1'b0;
                    s_nxt.irq_out  = s_r.output_irq_enable;
                    s_nxt.vec      = VEC_OUT;
                end else if (!s_r.response_pending_flag) begin
                    s_nxt.st = ST_IDLE;
                end
            end
            default: begin
                s_nxt.st = ST_INIT;
            end
        endcase

        if (s_r.run && i_evt_valid && !br_start) begin
            br_start      = 1'b1;
            br_start_trib = i_evt_trib;
        end

        // master clear throws away every exchange in flight except a cmd_valid or interrupt pulse raised in the same cycle
        if (s_nxt.mclr && !s_r.mclr) begin
            br_clear        = 1'b1;
            s_nxt.st        = ST_INIT;
            s_nxt.run       = 1'b0;
            s_nxt.input_irq_enable       = 1'b0;
            s_nxt.output_irq_enable       = 1'b0;
            s_nxt.port_request_flag       = 1'b0;
            s_nxt.port_granted_flag       = 1'b0;
            s_nxt.response_pending_flag       = 1'b0;
            s_nxt.rsp_pend  = 1'b0;
            s_nxt.slot_wait = 1'b0;
            s_nxt.init_cnt  = '0;
        end
    end

    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    // ==========================================================
    // outputs
    assign o_csr_rdata  = s_r.rdata;
    assign o_irq_in     = s_r.irq_in;
    assign o_irq_out    = s_r.irq_out;
    assign o_irq_vector = s_r.vec;
    assign o_cmd_valid  = s_r.cmd_valid;
    assign o_cmd        = s_r.cmd;
    assign o_running    = s_r.run;

endmodule

// file: core/ccrh_pkg.sv
package ccrh_pkg;

    // ==========================================================
    // byte register offsets on the host side
    localparam logic [2:0] OFF_CTRL_LOW  = 3'h0;
    localparam logic [2:0] OFF_CTRL_HIGH = 3'h1;
    localparam logic [2:0] OFF_HSK       = 3'h2;
    localparam logic [2:0] OFF_TRIB      = 3'h3;
    localparam logic [2:0] OFF_DLO       = 3'h4;
    localparam logic [2:0] OFF_DHI       = 3'h5;
    localparam logic [2:0] OFF_SEL       = 3'h6;

    // ==========================================================
    // field positions
    localparam int BIT_IEI       = 0;
    localparam int BIT_IEO       = 4;
    localparam int BIT_RQI       = 7;
    localparam int BIT_MCLR      = 6;
    localparam int BIT_RUN       = 7;
    localparam int BIT_RDI       = 4;
    localparam int BIT_RDO       = 7;
    localparam int BIT_SEL_READ  = 5;
    localparam int BIT_SEL_RDCLR = 6;
    localparam int SLOT_ADDR_W   = 5;

    // ==========================================================
    // command and response codes
    localparam logic [2:0] CMD_CONTROL  = 3'h1;
    localparam logic [2:0] RSP_BUF_DISP = 3'h0;
    localparam logic [2:0] RSP_INFO     = 3'h2;
    localparam logic [2:0] KEY_NONE     = 3'h0;
    localparam logic [2:0] KEY_MODEM    = 3'h1;
    localparam logic [2:0] KEY_READ     = 3'h2;
    localparam logic [2:0] KEY_RDCLR    = 3'h3;
    localparam logic [2:0] KEY_WRITE    = 3'h4;
    localparam logic [2:0] KEY_HALT     = 3'h5;
    localparam logic [4:0] RKEY_MODEM   = 5'h08;
    localparam logic [4:0] RKEY_BUFDONE = 5'h10;
    localparam logic [2:0] VEC_IN       = 3'h0;
    localparam logic [2:0] VEC_OUT      = 3'h4;

    // ==========================================================
    // timing
    localparam int CLK_PERIOD_NS = 10;
    localparam int INIT_TIME_NS  = 2000;
    localparam int INIT_CYCLES   = (INIT_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int INIT_CNT_W    = 8;

    // ==========================================================
    // types
    typedef enum logic [2:0] {
        ST_INIT  = 3'h0,
        ST_IDLE  = 3'h1,
        ST_GRANT = 3'h3,
        ST_EXEC  = 3'h2,
        ST_LOAD  = 3'h5,
        ST_POST  = 3'h4
    } ccrh_state_t;

    typedef struct packed {
        logic [7:0]  trib;
        logic [15:0] data;
        logic [7:0]  sel;
        logic [2:0]  code;
    } ccrh_msg_t;

endpackage

// file: core/ccrh_slot_mem.sv
`timescale 1ns/1ps
module ccrh_slot_mem
    import ccrh_pkg::*;
#(
    parameter int AW = 7
) (
    // clock and reset
    input  wire logic          i_clock,
    input  wire logic          i_rst,
    // access
    input  wire logic          i_rd,
    input  wire logic          i_rd_clr,
    input  wire logic          i_wr,
    input  wire logic [AW-1:0] i_addr,
    input  wire logic [15:0]   i_wdata,
    output logic      [15:0]   o_rdata
);

    // ==========================================================
    // storage
    typedef struct packed {
        logic [15:0] rdata;
    } ccrh_slot_state_t;

    logic [15:0]      mem_r [2**AW];
    ccrh_slot_state_t s_r;
    ccrh_slot_state_t s_nxt;

    always_comb begin
        s_nxt = s_r;
        if (i_rd) begin
            s_nxt.rdata = mem_r[i_addr];
        end
    end

    // old word is read out in the same edge that clears it
    always_ff @(posedge i_clock) begin
        if (i_wr) begin
            mem_r[i_addr] <= i_wdata;
        end else if (i_rd && i_rd_clr) begin
            mem_r[i_addr] <= 16'h0000;
        end
    end

    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign o_rdata = s_r.rdata;

endmodule

// file: core/ccrh_buf_return.sv
`timescale 1ns/1ps
module ccrh_buf_return
    import ccrh_pkg::*;
#(
    parameter int N_TRIB = 4,
    parameter int CNT_W  = 8
) (
    // clock and reset
    input  wire logic       i_clock,
    input  wire logic       i_rst,
    input  wire logic       i_clear,
    // buffers handed to the controller
    input  wire logic       i_assign,
    input  wire logic       i_assign_common,
    input  wire logic [7:0] i_assign_trib,
    // return requests
    input  wire logic       i_start,
    input  wire logic [7:0] i_start_trib,
    // returns towards the mailbox
    output logic            o_ret_valid,
    output logic [7:0]      o_ret_trib,
    input  wire logic       i_ret_taken,
    output logic            o_done_valid,
    output logic [7:0]      o_done_trib,
    input  wire logic       i_done_taken
);

    localparam int TW = (N_TRIB > 1) ? $clog2(N_TRIB) : 1;

    // ==========================================================
    // state
    typedef struct packed {
        logic [N_TRIB-1:0][CNT_W-1:0] priv;
        logic [CNT_W-1:0]             common;
        logic                         active;
        logic                         global_ret;
        logic [7:0]                   trib;
        logic                         done_pend;
    } ccrh_br_state_t;

    ccrh_br_state_t s_r;
    ccrh_br_state_t s_nxt;
    logic [CNT_W-1:0] cur;

    always_comb begin
        s_nxt = s_r;
        cur   = s_r.global_ret ? s_r.common : s_r.priv[s_r.trib[TW-1:0]];
        if (s_r.active) begin
            if (cur == '0) begin
                // completion only once every due buffer is gone
                s_nxt.active    = 1'b0;
                s_nxt.done_pend = 1'b1;
            end else if (i_ret_taken) begin
                if (s_r.global_ret) begin
                    s_nxt.common = s_r.common - 1'b1;
                end else begin
                    s_nxt.priv[s_r.trib[TW-1:0]] = cur - 1'b1;
                end
            end
        end
        if (i_done_taken) begin
            s_nxt.done_pend = 1'b0;
        end
        if (i_assign) begin
            if (i_assign_common) begin
                s_nxt.common = s_nxt.common + 1'b1;
            end else begin
                s_nxt.priv[i_assign_trib[TW-1:0]] = s_nxt.priv[i_assign_trib[TW-1:0]] + 1'b1;
            end
        end
        // a request during a running return is dropped, not queued
        if (i_start && !s_r.active && !s_r.done_pend) begin
            s_nxt.active     = 1'b1;
            s_nxt.global_ret = (i_start_trib == 8'h00);
            s_nxt.trib       = i_start_trib;
        end
        if (i_clear) begin
            s_nxt = '0;
        end
    end

    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign o_ret_valid  = s_r.active && (cur != '0);
    assign o_ret_trib   = s_r.global_ret ? 8'h00 : s_r.trib;
    assign o_done_valid = s_r.done_pend;
    assign o_done_trib  = s_r.global_ret ? 8'h00 : s_r.trib;

endmodule

// file: test/ccrh_mailbox_assertions.sv
`timescale 1ns/1ps
module ccrh_mailbox_assertions
    import ccrh_pkg::*;
#(
    parameter int N_TRIB = 4,
    parameter int CNT_W  = 8
) (
    // ==========
    // clock and reset
    input wire logic       i_clock,
    input wire logic       i_rst,
    // watched ports
    input wire logic [2:0] i_csr_addr,
    input wire logic       i_csr_wr,
    input wire logic [7:0] i_csr_wdata,
    input wire logic       o_irq_in,
    input wire logic       o_irq_out,
    input wire logic [2:0] o_irq_vector,
    input wire logic       o_running,
    input wire logic       o_cmd_valid
);
    default clocking @(posedge i_clock); endclocking
    default disable iff (i_rst);
    property p_in_vec; o_irq_in |-> o_irq_vector == VEC_IN; endproperty
    a_in_vec: assert property (p_in_vec) else $error("grant irq wrong vector");
    property p_out_vec; o_irq_out |-> o_irq_vector == VEC_OUT; endproperty
    a_out_vec: assert property (p_out_vec) else $error("response irq wrong vector");
    property p_in_pulse; o_irq_in |=> !o_irq_in; endproperty
    a_in_pulse: assert property (p_in_pulse) else $error("grant irq repeated");
    property p_out_pulse; o_irq_out |=> !o_irq_out; endproperty
    a_out_pulse: assert property (p_out_pulse) else $error("response irq repeated");
    property p_excl; !(o_irq_in && o_irq_out); endproperty
    a_excl: assert property (p_excl) else $error("grant and response together");
    property p_in_run; o_irq_in |-> o_running; endproperty
    a_in_run: assert property (p_in_run) else $error("grant before run");
    property p_cmd_run; o_cmd_valid || o_irq_out |-> o_running; endproperty
    a_cmd_run: assert property (p_cmd_run) else $error("activity before run");
    property p_run_hold;
        o_running && !(i_csr_wr && i_csr_addr == OFF_CTRL_HIGH && i_csr_wdata[BIT_MCLR]) |=> o_running;
    endproperty
    a_run_hold: assert property (p_run_hold) else $error("run dropped");
    c_in: cover property (o_irq_in);
    c_out: cover property (o_irq_out);
    c_cmd: cover property (o_cmd_valid);
endmodule
bind ccrh_mailbox ccrh_mailbox_assertions #(.N_TRIB(N_TRIB), .CNT_W(CNT_W)) u_chk (.i_clock, .i_rst,
    .i_csr_addr, .i_csr_wr, .i_csr_wdata, .o_irq_in, .o_irq_out, .o_irq_vector, .o_running, .o_cmd_valid);

// file: test/ccrh_host_model.sv
`timescale 1ns/1ps
module ccrh_host_model (
    // ==========
    // bus
    input  wire logic       i_clock,
    input  wire logic [7:0] i_rdata,
    output logic      [2:0] o_addr,
    output logic            o_wr,
    output logic            o_rd,
    output logic      [7:0] o_wdata
);
    initial begin
        {o_addr, o_wr, o_rd, o_wdata} = 13'h1c00;
    end
    // released lines show the inverse so a stale value never looks valid
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge i_clock);
        {o_addr, o_wdata, o_wr} <= {a, d, 1'b1};
        @(posedge i_clock);
        {o_addr, o_wdata, o_wr} <= {~a, ~d, 1'b0};
    endtask
    task automatic rd(input logic [2:0] a, output logic [7:0] d);
        @(posedge i_clock);
        {o_addr, o_rd} <= {a, 1'b1};
        @(posedge i_clock);
        {o_addr, o_rd} <= {~a, 1'b0};
        @(negedge i_clock);
        d = i_rdata;
    endtask
endmodule

// file: test/ccrh_mailbox_tb_top.sv
`timescale 1ns/1ps
module ccrh_mailbox_tb_top
    import ccrh_pkg::*;
;
    // ==========
    // signals
    logic i_clock = 0, i_rst = 1, i_evt_valid = 0, i_buf_assign = 0, i_buf_common = 0;
    logic [7:0] i_evt_trib = 0, i_buf_trib = 0, rdata, b, wd;
    logic [2:0] lc = 0;
    logic [2:0] addr, vin, vout;
    logic wr, rd, o_irq_in, o_irq_out, o_cmd_valid, o_running;
    logic [2:0] o_irq_vector;
    ccrh_msg_t o_cmd, cmd_seen;
    int errors = 0, total_checks = 0, n_in = 0, n_out = 0, n_cmd = 0, got_in = 0, got_out = 0;
    always #5 i_clock = ~i_clock;
    ccrh_mailbox u_ccrh_mailbox (.i_clock, .i_rst, .i_csr_addr(addr), .i_csr_wr(wr), .i_csr_rd(rd),
        .i_csr_wdata(wd), .o_csr_rdata(rdata), .o_irq_in, .o_irq_out, .o_irq_vector,
        .i_modem_status(16'h5a3c), .i_evt_valid, .i_evt_trib, .i_buf_assign, .i_buf_common, .i_buf_trib,
        .o_cmd_valid, .o_cmd, .o_running);
    ccrh_host_model u_ccrh_host_model (.i_clock, .i_rdata(rdata), .o_addr(addr), .o_wr(wr), .o_rd(rd), .o_wdata(wd));
    // pulses are one cycle wide, so count them here rather than poll from the tasks
    always @(negedge i_clock) begin
        if (o_irq_in === 1'b1) begin n_in++; vin = o_irq_vector; end
        if (o_irq_out === 1'b1) begin n_out++; vout = o_irq_vector; end
        if (o_cmd_valid === 1'b1) begin n_cmd++; cmd_seen = o_cmd; end
    end
    // ==========
    // tasks
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        total_checks++;
        if (seen !== exp) begin errors++; $display("mismatch t=%0t seen %h exp %h", $time, seen, exp); end
    endtask
    task automatic wait_ev(input bit out);
        int k;
        for (k = 0; k < 900 && (out ? n_out <= got_out : n_in <= got_in); k++) @(negedge i_clock);
        chk(k < 900, 1);
        if (out) begin got_out++; chk(vout, VEC_OUT); end
        else begin got_in++; chk(vin, VEC_IN); end
    endtask
    task automatic do_cmd(input logic [7:0] t, input logic [15:0] d, input logic [7:0] s, input logic [2:0] c,
                          input bit last);
        logic [7:0] r;
        wait_ev(0);
        u_ccrh_host_model.rd(OFF_HSK, r);
        chk(r, {5'h02, lc});
        if (last) u_ccrh_host_model.wr(OFF_CTRL_LOW, 8'h11);
        u_ccrh_host_model.wr(OFF_TRIB, t);
        u_ccrh_host_model.wr(OFF_DLO, d[7:0]);
        u_ccrh_host_model.wr(OFF_DHI, d[15:8]);
        u_ccrh_host_model.wr(OFF_SEL, s);
        u_ccrh_host_model.wr(OFF_HSK, {5'h0, c});
        lc = c;
    endtask
    task automatic get_rsp(input logic [2:0] c, input logic [7:0] t, input logic [15:0] d, input logic [7:0] s);
        logic [7:0] r;
        wait_ev(1);
        u_ccrh_host_model.rd(OFF_HSK, r);
        chk(r, {5'h10, c});
        u_ccrh_host_model.rd(OFF_TRIB, r);
        chk(r, t);
        u_ccrh_host_model.rd(OFF_DLO, r);
        chk(r, d[7:0]);
        u_ccrh_host_model.rd(OFF_DHI, r);
        chk(r, d[15:8]);
        u_ccrh_host_model.rd(OFF_SEL, r);
        chk(r, s);
        u_ccrh_host_model.wr(OFF_HSK, 8'h00);
        lc = 3'h0;
    endtask
    task automatic give(input logic ev, input logic com, input logic [7:0] t);
        @(posedge i_clock);
        {i_evt_valid, i_buf_assign, i_buf_common, i_buf_trib, i_evt_trib} <= {ev, !ev, com, t, t};
        @(posedge i_clock);
        {i_evt_valid, i_buf_assign} <= 2'h0;
    endtask
    task automatic close_out;
        $display("checks %0d errors %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    // ==========
    // tests
    initial begin
        #200000;
        errors++;
        close_out;
    end
    initial begin
        repeat (4) @(posedge i_clock);
        i_rst <= 1'b0;
        u_ccrh_host_model.rd(OFF_CTRL_HIGH, b);
        chk(b, 8'h00);
        u_ccrh_host_model.wr(OFF_CTRL_HIGH, 8'h40);
        for (int k = 0; k < 400 && o_running !== 1'b1; k++) @(negedge i_clock);
        u_ccrh_host_model.rd(OFF_CTRL_HIGH, b);
        chk(b, 8'h80);
        u_ccrh_host_model.rd(3'h7, b);
        chk(b, 8'h00);
        u_ccrh_host_model.wr(OFF_CTRL_LOW, 8'h91);
        u_ccrh_host_model.rd(OFF_CTRL_LOW, b);
        chk(b, 8'h91);
        do_cmd(8'h00, 16'h0000, 8'h20, CMD_CONTROL, 0);
        get_rsp(RSP_INFO, 8'h00, 16'h5a3c, 8'h08);
        do_cmd(8'h00, 16'habcd, 8'h83, CMD_CONTROL, 0);
        do_cmd(8'h00, 16'h0000, 8'h63, CMD_CONTROL, 0);
        get_rsp(RSP_INFO, 8'h00, 16'habcd, 8'h43);
        do_cmd(8'h00, 16'h0000, 8'h43, CMD_CONTROL, 0);
        get_rsp(RSP_INFO, 8'h00, 16'h0000, 8'h23);
        do_cmd(8'h05, 16'h1234, 8'h77, 3'h2, 0);
        repeat (4) @(negedge i_clock);
        chk(n_cmd, 1);
        chk({cmd_seen.sel, cmd_seen.trib}, 16'h7705);
        chk(cmd_seen.data, 16'h1234);
        chk(cmd_seen.code, 3'h2);
        give(0, 1, 8'h00);
        give(0, 1, 8'h00);
        give(0, 0, 8'h01);
        do_cmd(8'h00, 16'h0000, 8'ha0, CMD_CONTROL, 1);
        repeat (2) get_rsp(RSP_BUF_DISP, 8'h00, 16'h0000, 8'h00);
        get_rsp(RSP_INFO, 8'h00, 16'h0000, 8'h10);
        give(1, 0, 8'h01);
        get_rsp(RSP_BUF_DISP, 8'h01, 16'h0000, 8'h00);
        get_rsp(RSP_INFO, 8'h01, 16'h0000, 8'h10);
        close_out;
    end
endmodule
